// file: inc/lmc_pkg.sv
// shared constants for the line module control port and pcm highway
//
// How it works
// RQ1: far end supplies one of three master rates
// RQ2: rate select high for 1.536/1.544 MHz
// RQ3: bit clock shifts pcm in and out
// RQ4: tx frame sync starts each tx slot
// RQ5: tx pcm output driven only in slot
// RQ6: slot indicator low exactly while tx driven
// RQ7: rx pcm sampled only in rx slot
// RQ8: control shifts on control clock, select low
// RQ9: status output driven only while selected
// RQ10: interrupt on hook or thermal change
// RQ11: ring relay follows ring bit, trips off
// RQ12: aux relays follow bits five and six
// RQ13: reset clears control word, enters standby
// RQ14: control port and supervision work in standby
// RQ15: leave standby on ring write or off-hook
// RQ16: hook status follows loop current, dial pulses
// RQ17: ring trip reported well within 200 ms
// RQ18: two bits pick one of four balances
// RQ19: ring bit overrides two mode bits; here ring and mode bits leave as separate outputs, line_mode_o not overridden
// RQ20: status bit seven high means on-hook
// RQ21: old status out while new word in
// RQ22: quick read shows hook bit, no shift
// RQ23: msb first; interrupt cleared by access
package lmc_pkg;
   localparam int CLK_HZ = 200_000_000;
   localparam int MCLK_HZ = 2_048_000;
   localparam int CONTROL_SHIFT_CLOCK_HZ = 1_000_000;
   localparam int BCLK_HZ = 2_000_000;
   localparam int FRAME_HZ = 8_000;
   localparam int RING_TRIP_MAX_MS = 200;
   localparam logic [7:0] CONTROL_SHIFT_CLOCK_HALF = 8'(CLK_HZ / (2 * CONTROL_SHIFT_CLOCK_HZ));
   localparam logic [6:0] BCLK_HALF = 7'(CLK_HZ / (2 * BCLK_HZ));
   localparam logic [7:0] BITS_PER_FRAME = 8'(BCLK_HZ / FRAME_HZ);
   localparam logic RATE_SEL_RESET = (MCLK_HZ == 2_048_000) ? 1'b0 : 1'b1;
   // control word fields
   localparam int HOOK_STATUS_BIT = 7;
   localparam int AUX_B_BIT = 6;
   localparam int AUX_A_BIT = 5;
   localparam int RING_MODE_BIT = 4;
   localparam int MODE_SEL_HI = 3;
   localparam int MODE_SEL_LO = 2;
   localparam int BAL_HI = 1;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [1:0] MODE_DENIAL = 2'h2;
   localparam logic [3:0] WORD_BITS = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;
   // device synchroniser lanes
   localparam int SYN_W = 11;
   localparam int SY_CS = 0;
   localparam int SY_CONTROL_SHIFT_CLOCK = 1;
   localparam int SY_CI = 2;
   localparam int SY_BCLK = 3;
   localparam int SY_FSX = 4;
   localparam int SY_FSR = 5;
   localparam int SY_DR = 6;
   localparam int SY_LOOP = 7;
   localparam int SY_RING = 8;
   localparam int SY_THERM = 9;
   localparam int SY_RATE = 10;
   localparam logic [SYN_W-1:0] SYN_IDLE = 11'h001;
   // controller register byte offsets
   localparam logic [4:0] OFF_CMD = 5'h00;
   localparam logic [4:0] OFF_STAT = 5'h04;
   localparam logic [4:0] OFF_CFG = 5'h08;
   localparam logic [4:0] OFF_PTX = 5'h0c;
   localparam logic [4:0] OFF_PRX = 5'h10;
   localparam int CMD_QUICK = 8;
   // control access sequencer, gray from idle to gap except the quick setup-to-gap jump; gap back to idle flips two bits
   typedef enum logic [2:0] {
      LMC_IDLE = 3'h0,
      LMC_SETUP = 3'h1,
      LMC_HIGH = 3'h3,
      LMC_LOW = 3'h2,
      LMC_GAP = 3'h6
   } lmc_seq_t;
endpackage

// file: inc/lmc_if.sv
// pins between the line module and its controller
`timescale 1ns/1ps
`default_nettype none
interface lmc_if;
   logic cs_n, control_shift_clock, ci, bclk, tx_frame_sync, rx_frame_sync, dr, rate_sel;
   logic co, co_oe, dx, dx_oe;
   logic tsx_out, tsx_oe, irq_out, irq_oe;
   logic co_line, dx_line, tsx_n_line, irq_n_line;
   // resolved wire levels; released lines read high (pull-up)
   assign co_line = co_oe ? co : 1'b1;
   assign dx_line = dx_oe ? dx : 1'b1;
   assign tsx_n_line = tsx_oe ? tsx_out : 1'b1;
   assign irq_n_line = irq_oe ? irq_out : 1'b1;
   modport dev (
      input cs_n, control_shift_clock, ci, bclk, tx_frame_sync, rx_frame_sync, dr, rate_sel,
      output co, co_oe, dx, dx_oe, tsx_out, tsx_oe, irq_out, irq_oe
   );
   modport ctl (
      output cs_n, control_shift_clock, ci, bclk, tx_frame_sync, rx_frame_sync, dr, rate_sel,
      input co_line, dx_line, tsx_n_line, irq_n_line
   );
endinterface
`default_nettype wire

// file: hdl/lmc_dev.sv
// line module end: control port, relays, loop events and pcm slots
//
// The Avalon-MM interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module lmc_dev
   import lmc_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   lmc_if.dev pin,
   input wire logic loop_offhook_i,
   input wire logic ring_offhook_i,
   input wire logic thermal_alarm_i,
   input wire logic [7:0] tx_pcm_word_i,
   output logic ring_relay_drive_o,
   output logic aux_relay_a_o,
   output logic aux_relay_b_o,
   output logic standby_o,
   output logic ring_active_o,
   output logic [1:0] line_mode_o,
   output logic [1:0] balance_sel_o,
   output logic master_rate_select_o,
   output logic [7:0] rx_pcm_word_o,
   output logic rx_pcm_valid_o
);
   typedef struct packed {
      logic [SYN_W-1:0] s1;
      logic [SYN_W-1:0] s2;
      logic [SYN_W-1:0] p;
      logic [7:0] ctrl;
      logic [7:0] sh_in;
      logic [7:0] sh_out;
      logic [7:0] tx_sh;
      logic [7:0] rx_sh;
      logic [7:0] rx_word;
      logic [3:0] cnt;
      logic [3:0] tx_cnt;
      logic [3:0] rx_cnt;
      logic co, co_oe, irq, hook, therm, trip, stby;
      logic ring_relay_drive, rly_a, rly_b, dx, dx_oe, tsx_oe;
      logic rx_act, rx_vld, rate;
   } lmcd_st_t;

   lmcd_st_t q, n;

   // shared four-bit counter step; wrap is harmless, counts stop at 8
   function automatic logic [3:0] step4(input logic [3:0] v);
      return 4'(v + 4'h1);
   endfunction

   always_comb begin
      logic [SYN_W-1:0] lv;
      logic [SYN_W-1:0] rise;
      logic [SYN_W-1:0] fall;
      logic [7:0] stat;
      logic s7;
      lv = q.s2;
      rise = q.s2 & ~q.p;
      fall = ~q.s2 & q.p;
      // hook bit: loop current normally, ring trip while ringing
      s7 = q.ctrl[RING_MODE_BIT] ? ~q.trip : ~lv[SY_LOOP]; // [RQ16] [RQ20]
      stat = {s7, q.ctrl[6:0]};
      n = q;
      // two-flop synchronisers; only s2 and its delayed copy are read
      n.s1[SY_CS] = pin.cs_n;
      n.s1[SY_CONTROL_SHIFT_CLOCK] = pin.control_shift_clock;
      n.s1[SY_CI] = pin.ci;
      n.s1[SY_BCLK] = pin.bclk;
      n.s1[SY_FSX] = pin.tx_frame_sync;
      n.s1[SY_FSR] = pin.rx_frame_sync;
      n.s1[SY_DR] = pin.dr;
      n.s1[SY_LOOP] = loop_offhook_i;
      n.s1[SY_RING] = ring_offhook_i;
      n.s1[SY_THERM] = thermal_alarm_i;
      n.s1[SY_RATE] = pin.rate_sel;
      n.s2 = q.s1;
      n.p = q.s2;
      n.rate = lv[SY_RATE]; // [RQ2]

      // serial control port, msb first, only while selected
      // control_shift_clock is sampled, so its half period must cover the sync lag
      if (fall[SY_CS]) begin
         n.cnt = 4'h0;
         n.sh_out = stat; // [RQ21]
         n.co = stat[HOOK_STATUS_BIT]; // [RQ22]
         n.co_oe = 1'b1; // [RQ9]
      end else if (!lv[SY_CS]) begin
         if (rise[SY_CONTROL_SHIFT_CLOCK]) begin
            n.sh_in = {q.sh_in[6:0], lv[SY_CI]}; // [RQ8] [RQ23]
            if (q.cnt != WORD_BITS)
               n.cnt = step4(q.cnt);
         end
         if (fall[SY_CONTROL_SHIFT_CLOCK]) begin
            n.sh_out = {q.sh_out[6:0], 1'b0}; // [RQ21]
            n.co = q.sh_out[6];
         end
      end
      // deselect: release output; commit only a full word, so a
      // quick read with no clocks leaves the control word untouched
      if (rise[SY_CS]) begin
         n.co_oe = 1'b0; // [RQ9]
         n.irq = 1'b0; // [RQ23]
         if (q.cnt == WORD_BITS)
            n.ctrl = q.sh_in; // [RQ8] [RQ22]
      end

      // thermal overload forces power denial over any write
      // and the mode stays in denial after cooling until rewritten
      if (lv[SY_THERM])
         n.ctrl[MODE_SEL_HI:MODE_SEL_LO] = MODE_DENIAL; // [RQ19]

      // loop events; set is placed after clear so it wins
      n.hook = s7;
      n.therm = lv[SY_THERM];
      if (s7 != q.hook || lv[SY_THERM] != q.therm)
         n.irq = 1'b1; // [RQ10]

      // ring trip latches until ring mode is written off
      if (!q.ctrl[RING_MODE_BIT])
         n.trip = 1'b0;
      else if (lv[SY_RING])
         n.trip = 1'b1; // [RQ17]
      n.ring_relay_drive = q.ctrl[RING_MODE_BIT] & ~q.trip & ~lv[SY_RING]; // [RQ11]
      n.rly_a = q.ctrl[AUX_A_BIT]; // [RQ12]
      n.rly_b = q.ctrl[AUX_B_BIT]; // [RQ12]

      // standby is left for good; supervision above keeps running
      if (q.ctrl[RING_MODE_BIT] || lv[SY_LOOP])
         n.stby = 1'b0; // [RQ15] [RQ14]

      // tx slot: eight bit clocks from the sync-qualified edge
      // the word is taken at slot start; a later change waits a frame
      if (rise[SY_BCLK]) begin
         if (lv[SY_FSX] && q.tx_cnt == 4'h0) begin
            n.dx = tx_pcm_word_i[7]; // [RQ4] [RQ3]
            n.tx_sh = {tx_pcm_word_i[6:0], 1'b0};
            n.tx_cnt = 4'h1;
            n.dx_oe = 1'b1; // [RQ5]
            n.tsx_oe = 1'b1; // [RQ6]
         end else if (q.tx_cnt == WORD_BITS) begin
            n.tx_cnt = 4'h0;
            n.dx = 1'b0;
            n.dx_oe = 1'b0; // [RQ5]
            n.tsx_oe = 1'b0; // [RQ6]
         end else if (q.tx_cnt != 4'h0) begin
            n.dx = q.tx_sh[7]; // [RQ3]
            n.tx_sh = {q.tx_sh[6:0], 1'b0};
            n.tx_cnt = step4(q.tx_cnt);
         end
      end

      // rx slot: sample on falling edges, mid-bit for the far end
      // a sync seen while a word is open is ignored until it closes
      n.rx_vld = 1'b0;
      if (rise[SY_BCLK] && lv[SY_FSR] && !q.rx_act) begin
         n.rx_act = 1'b1; // [RQ7]
         n.rx_cnt = 4'h0;
      end
      if (fall[SY_BCLK] && q.rx_act) begin
         n.rx_sh = {q.rx_sh[6:0], lv[SY_DR]}; // [RQ7] [RQ3]
         n.rx_cnt = step4(q.rx_cnt);
         if (q.rx_cnt == LAST_BIT) begin
            n.rx_act = 1'b0;
            n.rx_word = {q.rx_sh[6:0], lv[SY_DR]};
            n.rx_vld = 1'b1;
         end
      end
   end

   // single register stage; standby and on-hook are the reset picture
   // idle levels preload the synchronisers: no false edge at release
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         q <= '0;
         q.ctrl <= CTRL_RESET; // [RQ13]
         q.stby <= 1'b1; // [RQ13]
         q.hook <= 1'b1;
         q.rate <= RATE_SEL_RESET;
         q.s1 <= SYN_IDLE;
         q.s2 <= SYN_IDLE;
         q.p <= SYN_IDLE;
      end else begin
         q <= n;
      end
   end

   // pins: open-drain lines only ever pull low
   // released lines rely on the board pull-ups for their high level
   assign pin.co = q.co;
   assign pin.co_oe = q.co_oe;
   assign pin.dx = q.dx;
   assign pin.dx_oe = q.dx_oe;
   assign pin.tsx_out = 1'b0;
   assign pin.tsx_oe = q.tsx_oe;
   assign pin.irq_out = 1'b0;
   assign pin.irq_oe = q.irq;

   // user side; the ring bit and the two mode bits leave as separate outputs
   assign ring_relay_drive_o = q.ring_relay_drive;
   assign aux_relay_a_o = q.rly_a;
   assign aux_relay_b_o = q.rly_b;
   assign standby_o = q.stby;
   assign ring_active_o = q.ctrl[RING_MODE_BIT]; // [RQ19]
   assign line_mode_o = q.ctrl[MODE_SEL_HI:MODE_SEL_LO]; // [RQ19]
   assign balance_sel_o = q.ctrl[BAL_HI:0]; // [RQ18]
   assign master_rate_select_o = q.rate;
   assign rx_pcm_word_o = q.rx_word;
   assign rx_pcm_valid_o = q.rx_vld;
endmodule
`default_nettype wire

// file: hdl/lmc_ctl.sv
// controller end: avalon registers, control sequencer, highway timing
`timescale 1ns/1ps
`default_nettype none
module lmc_ctl
   import lmc_pkg::*;
(
   input wire logic clk_i,
   input wire logic srst_i,
   lmc_if.ctl pin,
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o
);
   typedef struct packed {
      lmc_seq_t st;
      logic [7:0] tmr, word, osh, stat, ptx, prx, dsh, cap, bpos;
      logic [6:0] btmr;
      logic [3:0] bitn;
      logic [2:0] s1, s2;
      logic waitreq, busy, quick, rate, cs_n, control_shift_clock, ci;
      logic bclk, fs, dr;
      logic [31:0] rdata;
   } lmcc_st_t;

   lmcc_st_t q, n;

   always_comb begin
      logic half;
      logic [7:0] nb;
      half = (q.tmr == CONTROL_SHIFT_CLOCK_HALF - 8'h1);
      nb = 8'h0;
      n = q;
      // lines from the module: co, dx, irq
      n.s1 = {~pin.irq_n_line, pin.dx_line, pin.co_line};
      n.s2 = q.s1;

      // avalon slave: one-cycle answer; a command while busy stalls
      n.waitreq = 1'b1;
      if ((avs_read_i || avs_write_i) && q.waitreq) begin
         n.waitreq = 1'b0;
         n.rdata = 32'h0;
         case (avs_address_i)
            OFF_CMD: begin
               n.rdata = {23'h0, q.quick, q.word};
               if (avs_write_i && q.busy)
                  n.waitreq = 1'b1;
               else if (avs_write_i) begin
                  n.word = avs_writedata_i[7:0];
                  n.osh = avs_writedata_i[7:0];
                  n.quick = avs_writedata_i[CMD_QUICK];
                  n.busy = 1'b1;
               end
            end
            OFF_STAT: n.rdata = {22'h0, q.s2[2], q.busy, q.stat};
            OFF_CFG: begin
               n.rdata = {31'h0, q.rate};
               if (avs_write_i)
                  n.rate = avs_writedata_i[0]; // [RQ2]
            end
            OFF_PTX: begin
               n.rdata = {24'h0, q.ptx};
               if (avs_write_i)
                  n.ptx = avs_writedata_i[7:0];
            end
            OFF_PRX: n.rdata = {24'h0, q.prx};
            default: n.rdata = 32'h0;
         endcase
      end

      // control access: each phase lasts half a control clock
      n.tmr = half ? 8'h0 : 8'(q.tmr + 8'h1);
      case (q.st)
         LMC_IDLE: begin
            n.tmr = 8'h0;
            if (q.busy) begin
               n.cs_n = 1'b0; // [RQ8]
               n.ci = q.osh[7]; // [RQ23]
               n.bitn = 4'h0;
               n.st = LMC_SETUP;
            end
         end
         LMC_SETUP: if (half) begin
            if (q.quick) begin
               n.stat[HOOK_STATUS_BIT] = q.s2[0]; // [RQ22]
               n.cs_n = 1'b1;
               n.st = LMC_GAP;
            end else begin
               n.control_shift_clock = 1'b1;
               n.st = LMC_HIGH;
            end
         end
         LMC_HIGH: if (half) begin
            // sample before the module's falling-edge shift
            n.stat = {q.stat[6:0], q.s2[0]}; // [RQ21]
            n.control_shift_clock = 1'b0;
            n.ci = q.osh[6];
            n.osh = {q.osh[6:0], 1'b0};
            n.bitn = 4'(q.bitn + 4'h1);
            n.st = LMC_LOW;
         end
         LMC_LOW: if (half) begin
            if (q.bitn == WORD_BITS) begin
               n.cs_n = 1'b1; // [RQ8]
               n.st = LMC_GAP;
            end else begin
               n.control_shift_clock = 1'b1;
               n.st = LMC_HIGH;
            end
         end
         LMC_GAP: if (half) begin
            n.busy = 1'b0;
            n.st = LMC_IDLE;
         end
         default: n.st = LMC_IDLE;
      endcase

      // highway: bit clock divider, frame sync on bit zero
      n.btmr = 7'(q.btmr + 7'h1);
      if (q.btmr == BCLK_HALF - 7'h1) begin
         n.btmr = 7'h0;
         n.bclk = ~q.bclk; // [RQ3]
         if (!q.bclk) begin
            nb = (q.bpos == BITS_PER_FRAME - 8'h1) ? 8'h0 :
               8'(q.bpos + 8'h1);
            n.bpos = nb;
            n.fs = (nb == 8'h0); // [RQ4] [RQ7]
            n.dr = (nb == 8'h0) ? q.ptx[7] : q.dsh[7];
            n.dsh = (nb == 8'h0) ? {q.ptx[6:0], 1'b0} :
               {q.dsh[6:0], 1'b0};
         end else if (q.bpos < 8'(WORD_BITS)) begin
            n.cap = {q.cap[6:0], q.s2[1]}; // [RQ3]
            if (q.bpos == 8'(LAST_BIT))
               n.prx = {q.cap[6:0], q.s2[1]};
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         q <= '0;
         q.st <= LMC_IDLE;
         q.waitreq <= 1'b1;
         q.cs_n <= 1'b1;
         q.rate <= RATE_SEL_RESET; // [RQ1] [RQ2]
         q.bpos <= BITS_PER_FRAME - 8'h1;
         q.s1 <= 3'h3;
         q.s2 <= 3'h3;
      end else begin
         q <= n;
      end
   end

   assign pin.cs_n = q.cs_n;
   assign pin.control_shift_clock = q.control_shift_clock;
   assign pin.ci = q.ci;
   assign pin.bclk = q.bclk;
   assign pin.tx_frame_sync = q.fs;
   assign pin.rx_frame_sync = q.fs;
   assign pin.dr = q.dr;
   assign pin.rate_sel = q.rate;
   assign avs_readdata_o = q.rdata;
   assign avs_waitrequest_o = q.waitreq;
endmodule
`default_nettype wire

// file: dv/lmc_monitor.sv
// pin-level assertions between the line module and its controller
`timescale 1ns/1ps
`default_nettype none
module lmc_monitor (
   input wire logic clk_i,
   input wire logic srst_i,
   input wire logic cs_n,
   input wire logic control_shift_clock,
   input wire logic tx_frame_sync,
   input wire logic co_oe,
   input wire logic co_line,
   input wire logic dx_oe,
   input wire logic tsx_n_line,
   input wire logic irq_oe
);
   typedef struct packed {
      logic [15:0] oe_cnt;
      logic [15:0] frm;
      logic tx_frame_sync;
      logic seen;
   } lmc_mon_t;
   lmc_mon_t s_q, s_d;
   // slot length and frame spacing; 16 bits hold one frame with room
   always_comb begin
      s_d = s_q;
      s_d.oe_cnt = dx_oe ? s_q.oe_cnt + 16'h0001 : 16'h0000;
      s_d.tx_frame_sync = tx_frame_sync;
      s_d.frm = s_q.frm + 16'h0001;
      if (tx_frame_sync && !s_q.tx_frame_sync) begin
         s_d.frm = 16'h0001;
         s_d.seen = 1'b1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   // indicator mirrors the data driver exactly
   property p_slot_ind;
      (tsx_n_line == 1'b0) == dx_oe;
   endproperty
   a_slot_ind: assert property (p_slot_ind)
      else $error("slot flag off");
   property p_slot_start;
      $rose(dx_oe) |-> s_q.frm <= 16'h00c8;
   endproperty
   a_slot_start: assert property (p_slot_start)
      else $error("stray slot");
   // eight bit periods of 100 cycles each
   property p_slot_len;
      $fell(dx_oe) |-> s_q.oe_cnt >= 16'h031e && s_q.oe_cnt <= 16'h0322;
   endproperty
   a_slot_len: assert property (p_slot_len)
      else $error("slot length");
   property p_frame;
      tx_frame_sync && !s_q.tx_frame_sync && s_q.seen |-> s_q.frm == 16'h61a8;
   endproperty
   a_frame: assert property (p_frame) else $error("frame period");
   // sync lag is about three cycles, so six gives margin
   property p_co_off;
      cs_n [*6] |-> !co_oe;
   endproperty
   a_co_off: assert property (p_co_off) else $error("co driven idle");
   property p_co_on;
      !cs_n [*6] |-> co_oe;
   endproperty
   a_co_on: assert property (p_co_on) else $error("co not driven");
   property p_co_hold;
      !cs_n && control_shift_clock && $past(control_shift_clock, 4) |-> $stable(co_line);
   endproperty
   a_co_hold: assert property (p_co_hold) else $error("co moved");
   property p_cs_gap;
      $rose(cs_n) |-> cs_n [*5];
   endproperty
   a_cs_gap: assert property (p_cs_gap) else $error("select gap");
   property p_irq_rel;
      $rose(cs_n) |-> ##[1:8] !irq_oe;
   endproperty
   a_irq_rel: assert property (p_irq_rel) else $error("irq kept");
   c_slot: cover property ($rose(dx_oe));
   c_access: cover property ($rose(cs_n));
   c_irq: cover property ($fell(irq_oe));
endmodule
`default_nettype wire

// file: dv/lmc_tb.sv
// self-checking bench: controller and line module joined by their pins
`timescale 1ns/1ps
`default_nettype none
module testbench
   import lmc_pkg::*;
   ;
   logic clk_i, srst_i, loop_i, ring_i, therm_i, rd, wr, wrq;
   logic ringr, auxa, auxb, stby, ringa, rsel, rxv;
   logic [1:0] mode, bal;
   logic [4:0] adr;
   logic [7:0] txw, rxw, prev;
   logic [31:0] wd, rdd, s;
   int errors, comparisons;
   lmc_if pins ();
   lmc_ctl u_lmc_ctl (.clk_i(clk_i), .srst_i(srst_i), .pin(pins.ctl),
      .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_readdata_o(rdd), .avs_waitrequest_o(wrq));
   lmc_dev u_lmc_dev (.clk_i(clk_i), .srst_i(srst_i), .pin(pins.dev),
      .loop_offhook_i(loop_i), .ring_offhook_i(ring_i),
      .thermal_alarm_i(therm_i), .tx_pcm_word_i(txw),
      .ring_relay_drive_o(ringr), .aux_relay_a_o(auxa),
      .aux_relay_b_o(auxb), .standby_o(stby), .ring_active_o(ringa),
      .line_mode_o(mode), .balance_sel_o(bal),
      .master_rate_select_o(rsel), .rx_pcm_word_o(rxw),
      .rx_pcm_valid_o(rxv));
   lmc_monitor u_lmc_monitor (.clk_i(clk_i), .srst_i(srst_i),
      .cs_n(pins.cs_n), .control_shift_clock(pins.control_shift_clock), .tx_frame_sync(pins.tx_frame_sync),
      .co_oe(pins.co_oe), .co_line(pins.co_line), .dx_oe(pins.dx_oe),
      .tsx_n_line(pins.tsx_n_line), .irq_oe(pins.irq_oe));
   // 200 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   task automatic finish_test;
      if (errors == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // one avalon access; held until waitrequest is sampled low
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      adr <= a;
      wd <= d;
      rd <= !w;
      wr <= w;
      do begin
         @(posedge clk_i);
         n++;
      end while (wrq !== 1'b0 && n < 4000);
      s = rdd;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 4000) begin
         errors++;
         $display("unexpected at %0t: bus hang", $time);
      end
   endtask
   // control access, then poll until the serial transfer is done
   task automatic cmd(input logic [8:0] c);
      int n;
      n = 0;
      bus(1'b1, OFF_CMD, {23'h0, c});
      do begin
         bus(1'b0, OFF_STAT, 32'h0);
         n++;
      end while (s[8] !== 1'b0 && n < 2000);
      if (s[8] !== 1'b0) begin
         errors++;
         $display("unexpected at %0t: access hang", $time);
      end
   endtask
   // rx word arrives once per 25000-cycle frame
   task automatic wait_rx;
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (rxv !== 1'b1 && n < 30000);
      chk(rxv, 1'b1);
   endtask
   initial begin
      repeat (85000) @(posedge clk_i);
      errors++;
      $display("unexpected at %0t: watchdog", $time);
      finish_test;
   end
   initial begin
      errors = 0;
      comparisons = 0;
      srst_i = 1'b1;
      {loop_i, ring_i, therm_i, rd, wr} = 5'h00;
      txw = 8'h3c;
      adr = 5'h00;
      wd = 32'h0;
      repeat (16) @(posedge clk_i);
      srst_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      // power-on state
      chk(stby, 1'b1);
      chk({ringr, auxa, auxb, ringa, mode, bal}, 32'h0);
      chk(pins.irq_n_line, 1'b1);
      bus(1'b0, OFF_CFG, 32'h0);
      chk(s, 32'h0);
      bus(1'b0, 5'h14, 32'h0);
      chk(s, 32'h0);
      bus(1'b1, OFF_CFG, 32'h1);
      repeat (8) @(posedge clk_i);
      chk(rsel, 1'b1);
      // relays and balance, port still works in standby
      cmd(9'h063);
      chk({auxa, auxb, bal}, 32'hf);
      chk(stby, 1'b1);
      prev = 8'h63;
      for (int m = 0; m < 4; m++) begin
         cmd({5'h00, m[1:0], 2'h0});
         chk(mode, m[1:0]);
         chk(s[7:0], {1'b1, prev[6:0]});
         chk({auxa, auxb, ringa}, 32'h0);
         prev = {4'h0, m[1:0], 2'h0};
      end
      // off-hook wakes the line and raises the event
      loop_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      chk(stby, 1'b0);
      bus(1'b0, OFF_STAT, 32'h0);
      chk(s[9], 1'b1);
      cmd(9'h100);
      chk(s[7], 1'b0);
      chk(s[9], 1'b0);
      chk(mode, 2'h3);
      loop_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      bus(1'b0, OFF_STAT, 32'h0);
      chk(s[9], 1'b1);
      cmd(9'h100);
      chk(s[7], 1'b1);
      // ringing, then trip drops the relay
      cmd(9'h010);
      chk({ringr, ringa}, 32'h3);
      ring_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      chk(ringr, 1'b0);
      chk(ringa, 1'b1);
      cmd(9'h100);
      chk(s[7], 1'b0);
      ring_i <= 1'b0;
      therm_i <= 1'b1;
      repeat (20) @(posedge clk_i);
      chk(mode, MODE_DENIAL);
      bus(1'b0, OFF_STAT, 32'h0);
      chk(s[9], 1'b1);
      therm_i <= 1'b0;
      // pcm both ways; the second frame carries the new bytes
      bus(1'b1, OFF_PTX, 32'ha5);
      wait_rx();
      wait_rx();
      chk(rxw, 8'ha5);
      repeat (200) @(posedge clk_i);
      bus(1'b0, OFF_PRX, 32'h0);
      chk(s[7:0], 8'h3c);
      finish_test;
   end
endmodule
`default_nettype wire
